/* File: wdt_defs.vh */
// register map, field positions, reset values and timing figures of the watchdog timer
`ifndef WDT_DEFS_VH
`define WDT_DEFS_VH

// register byte offsets
`define WDT_OFS_LOAD_VALUE 12'h000
`define WDT_OFS_CURRENT_COUNT 12'h004
`define WDT_OFS_CONTROL 12'h008
`define WDT_OFS_IRQ_CLEAR 12'h00C
`define WDT_OFS_RAW_IRQ_STATE 12'h010
`define WDT_OFS_MASKED_IRQ_STATE 12'h014
`define WDT_OFS_CLK_SELECT 12'h018
`define WDT_OFS_EVENT_STATUS 12'h01C
`define WDT_OFS_EVENT_MASK 12'h020
`define WDT_OFS_WRITE_PROTECT_KEY 12'hC00

// address width of the register port
`define WDT_ADDR_W 12

// control register fields
`define WDT_CTRL_IRQ_ENABLE 0
`define WDT_CTRL_RESET_OUTPUT_ENABLE 1

// clock select register field: 0 internal rc, 1 external crystal
`define WDT_CLKSEL_BIT 0

// event status and mask layout
`define WDT_EVT_EXPIRY 0
`define WDT_EVT_RESET 1
`define WDT_EVT_NUM 2

// reset values
`define WDT_RELOAD_RESET 32'h0FFFFFFF
`define WDT_COUNT_RESET 32'h0FFFFFFF
`define WDT_CONTROL_RESET 2'h0

// key that opens the other registers to writes
`define WDT_PROTECTION_KEY 32'h1ACCE551

// nominal counter clock rate in hz
`define WDT_TICK_HZ 32768
// register clock rate in hz
`define WDT_REF_HZ 40000000

`endif

/* File: wdt_top.v */
// watchdog timer: 32-bit down counter on the 32 kHz tick with register port and reset output
//
// The strobed register port was decided locally.
`timescale 1ns/1ps
`include "wdt_defs.vh"

// Overview of operation
// R1: a 32-bit counter steps down once per tick of the selected 32 kHz oscillator.
// R2: interrupts come load value plus one ticks apart.
// R3: on reaching zero the counter sets the raw interrupt state and reloads from the load value.
// R4: clearing the interrupt reloads the counter from the load value.
// R5: reaching zero again while the raw interrupt state is set raises the system reset.
// R6: with the interrupt disabled the counter holds, and enabling restarts it from the load value.
// R7: writing the key opens the other registers to writes, any other value closes them.
// R8: the protection register reads 0 when open and 1 when closed.
// R9: writing the load value restarts the count from the new value at once.
// R10: the current count register returns the live count and ignores writes.
// R11: control bit 0 enables the interrupt and bit 1 the reset output, both reset to zero.
// R12: any write to the clear register clears the interrupt and reloads, and it reads zero; wdt_irq stays set until the event status is read.
// R13: raw state bit 0 shows the unmasked interrupt and ignores writes.
// R14: masked state bit 0 shows the masked interrupt and ignores writes.
// R15: software writes reserved fields with their default values.
// R16: masked state is raw state and interrupt enable, and reset needs the reset enable.
// R17: tick edges from the 32 kHz source are synchronised before they touch the count.
module wdt_top (
  input wire ref_clk,
  input wire rst_n,
  input wire [`WDT_ADDR_W-1:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output wire [31:0] reg_rdata,
  input wire internal_rc_osc,
  input wire external_crystal_osc,
  output wire wdt_irq,
  output wire sys_reset_req
);

  // register state
  reg [31:0] reload_register_q;
  reg [31:0] present_count_q;
  reg [31:0] present_count_d;
  reg irq_enable_q;
  reg reset_output_enable_q;
  reg clk_select_q;
  reg raw_irq_flag_q;
  reg raw_irq_flag_d;
  reg protect_closed_q;
  reg expiry_monitor_q;
  reg irq_enable_prev_q;
  reg [`WDT_EVT_NUM-1:0] event_status_q;
  reg [`WDT_EVT_NUM-1:0] event_mask_q;
  reg [31:0] rdata_q;
  reg [31:0] rdata_d;

  // tick synchroniser chain
  reg osc_meta_q;
  reg osc_sync_q;
  reg osc_prev_q;

  // decoded strobes and helpers
  wire osc_sel;
  wire tick;
  wire wr_open;
  wire hit_load;
  wire hit_control;
  wire hit_clear;
  wire hit_clksel;
  wire hit_evmask;
  wire hit_key;
  wire rd_evstat;
  wire count_zero;
  wire expire;
  wire second_expiry;
  wire enable_rise;
  wire masked_irq_flag;
  wire [`WDT_EVT_NUM-1:0] event_set;

  // R1 source select
  // the oscillators are muxed raw; a glitch at a switch costs at most one tick
  assign osc_sel = clk_select_q ? external_crystal_osc : internal_rc_osc;

  // R17 tick synchroniser
  // the 32 kHz level is asynchronous to ref_clk, so two flops before any edge detect
  always @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      osc_meta_q <= 1'b0;
      osc_sync_q <= 1'b0;
      osc_prev_q <= 1'b0;
    end
    else
    begin
      osc_meta_q <= osc_sel;
      osc_sync_q <= osc_meta_q;
      osc_prev_q <= osc_sync_q;
    end
  end

  // one ref_clk pulse per rising edge of the slow clock
  assign tick = osc_sync_q & ~osc_prev_q;

  // R7 write gating
  // every register but the key itself obeys the protection state
  assign wr_open = reg_wr & ~protect_closed_q;

  // address decode of the write side
  assign hit_load = wr_open & (reg_addr == `WDT_OFS_LOAD_VALUE);
  assign hit_control = wr_open & (reg_addr == `WDT_OFS_CONTROL);
  assign hit_clear = wr_open & (reg_addr == `WDT_OFS_IRQ_CLEAR);
  assign hit_clksel = wr_open & (reg_addr == `WDT_OFS_CLK_SELECT);
  assign hit_evmask = wr_open & (reg_addr == `WDT_OFS_EVENT_MASK);
  assign hit_key = reg_wr & (reg_addr == `WDT_OFS_WRITE_PROTECT_KEY);

  // a read of event status is what clears it
  assign rd_evstat = reg_rd & (reg_addr == `WDT_OFS_EVENT_STATUS);

  // R6 enable edge
  // restarting from the load value, not the stale count, needs the old enable
  assign enable_rise = irq_enable_q & ~irq_enable_prev_q;

  // R3 expiry detect
  // expiry only counts while enabled, since a stopped counter never steps
  assign count_zero = (present_count_q == 32'h00000000);
  assign expire = tick & irq_enable_q & count_zero;

  // R5 second expiry
  // a clear in the same cycle does not rescue it: the earlier expiry was not served
  assign second_expiry = expire & raw_irq_flag_q;

  // R16 masked state
  assign masked_irq_flag = raw_irq_flag_q & irq_enable_q;

  // R1 R2 R3 R4 R6 R9 counter next value
  // priority: load write, then clear, then enable restart, then tick
  always @*
  begin
    present_count_d = present_count_q;
    if (hit_load)
    begin
      // R9 immediate restart
      present_count_d = reg_wdata;
    end
    else if (hit_clear)
    begin
      // R4 reload on clear
      present_count_d = reload_register_q;
    end
    else if (enable_rise)
    begin
      // R6 restart from load
      present_count_d = reload_register_q;
    end
    else if (tick & irq_enable_q)
    begin
      // R2 zero is one tick, so the period is load plus one
      if (count_zero)
      begin
        present_count_d = reload_register_q;
      end
      else
      begin
        present_count_d = present_count_q - 32'h00000001;
      end
    end
  end

  // R3 R12 raw interrupt state
  // an expiry in the cycle of a clear wins, so no event is lost
  always @*
  begin
    raw_irq_flag_d = raw_irq_flag_q;
    if (hit_clear)
    begin
      raw_irq_flag_d = 1'b0;
    end
    if (expire)
    begin
      raw_irq_flag_d = 1'b1;
    end
  end

  // counter and raw state flops
  always @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      present_count_q <= `WDT_COUNT_RESET;
      raw_irq_flag_q <= 1'b0;
      irq_enable_prev_q <= 1'b0;
    end
    else
    begin
      present_count_q <= present_count_d;
      raw_irq_flag_q <= raw_irq_flag_d;
      irq_enable_prev_q <= irq_enable_q;
    end
  end

  // R9 load register store
  always @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      reload_register_q <= `WDT_RELOAD_RESET;
    end
    else if (hit_load)
    begin
      reload_register_q <= reg_wdata;
    end
  end

  // R11 control bits
  // reserved upper bits are not stored and read back as zero
  always @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      irq_enable_q <= 1'b0;
      reset_output_enable_q <= 1'b0;
    end
    else if (hit_control)
    begin
      irq_enable_q <= reg_wdata[`WDT_CTRL_IRQ_ENABLE];
      reset_output_enable_q <= reg_wdata[`WDT_CTRL_RESET_OUTPUT_ENABLE];
    end
  end

  // oscillator select and event mask
  always @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      clk_select_q <= 1'b0;
      event_mask_q <= {`WDT_EVT_NUM{1'b0}};
    end
    else
    begin
      if (hit_clksel)
      begin
        clk_select_q <= reg_wdata[`WDT_CLKSEL_BIT];
      end
      if (hit_evmask)
      begin
        event_mask_q <= reg_wdata[`WDT_EVT_NUM-1:0];
      end
    end
  end

  // R7 protection state
  // the key register stays writable while closed, otherwise a lock could never be lifted
  always @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      protect_closed_q <= 1'b0;
    end
    else if (hit_key)
    begin
      protect_closed_q <= (reg_wdata != `WDT_PROTECTION_KEY);
    end
  end

  // R5 R16 system reset request
  // held until rst_n, since the system reset this asks for resets the block too
  always @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      expiry_monitor_q <= 1'b0;
    end
    else if (second_expiry & reset_output_enable_q)
    begin
      expiry_monitor_q <= 1'b1;
    end
  end

  assign sys_reset_req = expiry_monitor_q;

  // sticky event sources: every expiry, and a reset request being raised
  assign event_set[`WDT_EVT_EXPIRY] = expire;
  assign event_set[`WDT_EVT_RESET] = second_expiry & reset_output_enable_q;

  // sticky event bits, cleared by a read; a set in the read cycle wins
  genvar gi;
  generate
    for (gi = 0; gi < `WDT_EVT_NUM; gi = gi + 1)
    begin : g_evt
      always @(posedge ref_clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          event_status_q[gi] <= 1'b0;
        end
        else if (event_set[gi])
        begin
          event_status_q[gi] <= 1'b1;
        end
        else if (rd_evstat)
        begin
          event_status_q[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  // level interrupt while any unmasked event bit is set
  assign wdt_irq = |(event_status_q & event_mask_q);

  // R8 R10 R12 R13 R14 read mux
  // unmapped offsets and write-only registers answer zero
  always @*
  begin
    rdata_d = 32'h00000000;
    if (reg_rd)
    begin
      case (reg_addr)
        `WDT_OFS_LOAD_VALUE:
        begin
          rdata_d = reload_register_q;
        end
        `WDT_OFS_CURRENT_COUNT:
        begin
          // R10 live count
          rdata_d = present_count_q;
        end
        `WDT_OFS_CONTROL:
        begin
          rdata_d[`WDT_CTRL_IRQ_ENABLE] = irq_enable_q;
          rdata_d[`WDT_CTRL_RESET_OUTPUT_ENABLE] = reset_output_enable_q;
        end
        `WDT_OFS_IRQ_CLEAR:
        begin
          // R12 reads zero
          rdata_d = 32'h00000000;
        end
        `WDT_OFS_RAW_IRQ_STATE:
        begin
          // R13 raw flag
          rdata_d[0] = raw_irq_flag_q;
        end
        `WDT_OFS_MASKED_IRQ_STATE:
        begin
          // R14 masked flag
          rdata_d[0] = masked_irq_flag;
        end
        `WDT_OFS_CLK_SELECT:
        begin
          rdata_d[`WDT_CLKSEL_BIT] = clk_select_q;
        end
        `WDT_OFS_EVENT_STATUS:
        begin
          rdata_d[`WDT_EVT_NUM-1:0] = event_status_q;
        end
        `WDT_OFS_EVENT_MASK:
        begin
          rdata_d[`WDT_EVT_NUM-1:0] = event_mask_q;
        end
        `WDT_OFS_WRITE_PROTECT_KEY:
        begin
          // R8 lock status
          rdata_d[0] = protect_closed_q;
        end
        default:
        begin
          rdata_d = 32'h00000000;
        end
      endcase
    end
  end

  // read data stand only in the cycle after the strobe
  always @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rdata_q <= 32'h00000000;
    end
    else
    begin
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;

endmodule // wdt_top

/* File: wdt_top_asserts.sv */
// checker of the watchdog timer register port and reset output
`timescale 1ns/1ps
module wdt_chk (
  input wire ref_clk,
  input wire rst_n,
  input wire [11:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [31:0] reg_rdata,
  input wire internal_rc_osc,
  input wire external_crystal_osc,
  input wire wdt_irq,
  input wire sys_reset_req
);
  reg open_q;
  reg [1:0] ctrl_q;
  reg [31:0] load_q;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // shadow of the lock-gated registers; a closed lock must swallow writes
  always @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      open_q <= 1'b1;
      ctrl_q <= 2'h0;
      load_q <= 32'h0FFFFFFF;
    end
    else if (reg_wr)
    begin
      if (reg_addr == 12'hC00)
        open_q <= (reg_wdata == 32'h1ACCE551);
      if (open_q && reg_addr == 12'h008)
        ctrl_q <= reg_wdata[1:0];
      if (open_q && reg_addr == 12'h000)
        load_q <= reg_wdata;
    end
  end
  clr_zero_a: assert property ($past(reg_rd && reg_addr == 12'h00C) |-> reg_rdata == 32'h0)
    else $error("clear register reads nonzero");
  lock_status_a: assert property ($past(reg_rd && reg_addr == 12'hC00)
    |-> reg_rdata == {31'h0, !$past(open_q)}) else $error("lock status wrong");
  load_read_a: assert property ($past(reg_rd && reg_addr == 12'h000)
    |-> reg_rdata == $past(load_q)) else $error("load value wrong");
  ctrl_read_a: assert property ($past(reg_rd && reg_addr == 12'h008)
    |-> reg_rdata == {30'h0, $past(ctrl_q)}) else $error("control wrong");
  raw_rsvd_a: assert property ($past(reg_rd && reg_addr == 12'h010)
    |-> reg_rdata[31:1] == 31'h0) else $error("raw state reserved bits set");
  masked_gate_a: assert property ($past(reg_rd && reg_addr == 12'h014 && !ctrl_q[0])
    |-> reg_rdata == 32'h0) else $error("masked state set while disabled");
  reset_sticky_a: assert property (sys_reset_req |=> sys_reset_req)
    else $error("reset request dropped");
  reset_gate_a: assert property ($rose(sys_reset_req) |-> $past(ctrl_q[1]))
    else $error("reset request without enable");
  cover property ($rose(sys_reset_req));
  cover property ($rose(wdt_irq));
  cover property ($past(reg_rd && reg_addr == 12'hC00) && reg_rdata[0]);
endmodule // wdt_chk

bind wdt_top wdt_chk chk_u (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .internal_rc_osc(internal_rc_osc), .external_crystal_osc(external_crystal_osc),
  .wdt_irq(wdt_irq), .sys_reset_req(sys_reset_req));

/* File: wdt_osc_model.sv */
// model of the two 32 kHz sources, sped up so a run stays short
`timescale 1ns/1ps
module wdt_osc_model #(
  parameter HALF_NS = 250
) (
  input wire crystal_run,
  output reg rc_clk,
  output reg crystal_clk
);
  // rc source runs free from power-up
  initial
  begin
    rc_clk = 1'b0;
    forever #(HALF_NS) rc_clk = ~rc_clk;
  end
  // crystal stands still until started, so a count on it freezes
  initial
  begin
    crystal_clk = 1'b0;
    forever
    begin
      #(HALF_NS);
      if (crystal_run)
        crystal_clk = ~crystal_clk;
    end
  end
endmodule // wdt_osc_model

/* File: wdt_testbench.sv */
// self-checking testbench of the watchdog timer
`timescale 1ns/1ps
module testbench;
  localparam TICK = 20; // ref_clk cycles per oscillator period
  reg ref_clk, rst_n, reg_wr, reg_rd, crystal_run;
  reg [11:0] reg_addr;
  reg [31:0] reg_wdata, rv;
  wire [31:0] reg_rdata;
  wire rc_clk, crystal_clk, wdt_irq, sys_reset_req;
  integer fails, n_checks, cyc, t0;

  wdt_osc_model osc_u (.crystal_run(crystal_run), .rc_clk(rc_clk), .crystal_clk(crystal_clk));
  wdt_top dut_u (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .internal_rc_osc(rc_clk),
    .external_crystal_osc(crystal_clk), .wdt_irq(wdt_irq), .sys_reset_req(sys_reset_req));

  // clock and a cycle ceiling that cuts a hang short
  initial
  begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk)
  begin
    cyc = cyc + 1;
    if (cyc == 20000)
    begin
      fails = fails + 1;
      finish_test;
    end
  end

  task finish_test;
  begin
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
  begin
    n_checks = n_checks + 1;
    if (got !== exp)
    begin
      fails = fails + 1;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  end
  endtask
  task wr(input [11:0] a, input [31:0] d);
  begin
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  end
  endtask
  // read data stand only in the cycle after the strobe
  task rdchk(input [11:0] a, input [31:0] e);
  begin
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 rv = reg_rdata;
    chk(rv, e);
  end
  endtask

  initial
  begin
    fails = 0;
    n_checks = 0;
    cyc = 0;
    rst_n = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 12'h0;
    reg_wdata = 32'h0;
    crystal_run = 1'b0;
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'b1;
    rdchk(12'h000, 32'h0FFFFFFF);
    rdchk(12'h004, 32'h0FFFFFFF);
    rdchk(12'h008, 32'h0);
    rdchk(12'h00C, 32'h0);
    rdchk(12'h010, 32'h0);
    rdchk(12'h014, 32'h0);
    rdchk(12'hC00, 32'h0);
    rdchk(12'h100, 32'h0);
    // stopped crystal selected, so the count holds for exact reads
    wr(12'h018, 32'h1);
    wr(12'h000, 32'h5);
    rdchk(12'h004, 32'h5);
    wr(12'h004, 32'h77);
    wr(12'h010, 32'h1);
    rdchk(12'h004, 32'h5);
    rdchk(12'h010, 32'h0);
    wr(12'h020, 32'h3);
    wr(12'h008, 32'h3);
    rdchk(12'h008, 32'h3);
    // start the crystal: interrupt, then reset on the unserved second expiry
    crystal_run <= 1'b1;
    while (!wdt_irq) @(posedge ref_clk);
    t0 = cyc;
    rdchk(12'h010, 32'h1);
    rdchk(12'h014, 32'h1);
    rdchk(12'h01C, 32'h1);
    chk({31'h0, wdt_irq}, 32'h0);
    while (!sys_reset_req) @(posedge ref_clk);
    chk({31'h0, (cyc - t0 >= 6 * TICK - 2) && (cyc - t0 <= 6 * TICK + 2)}, 32'h1);
    // the second expiry and the reset request both leave sticky event bits
    rdchk(12'h01C, 32'h3);
    // second reset in mid-run clears the sticky request
    rst_n <= 1'b0;
    crystal_run <= 1'b0;
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'b1;
    chk({31'h0, sys_reset_req}, 32'h0);
    wr(12'hC00, 32'h0);
    rdchk(12'hC00, 32'h1);
    wr(12'h000, 32'h9);
    rdchk(12'h000, 32'h0FFFFFFF);
    wr(12'hC00, 32'h1ACCE551);
    rdchk(12'hC00, 32'h0);
    wr(12'h000, 32'h9);
    rdchk(12'h000, 32'h9);
    // rc source, interrupt only: a second expiry must not reset
    wr(12'h020, 32'h1);
    wr(12'h008, 32'h1);
    while (!wdt_irq) @(posedge ref_clk);
    repeat (12 * TICK) @(posedge ref_clk);
    chk({31'h0, sys_reset_req}, 32'h0);
    rdchk(12'h014, 32'h1);
    wr(12'h008, 32'h0);
    rdchk(12'h014, 32'h0);
    rdchk(12'h010, 32'h1);
    wr(12'h00C, 32'hA5);
    rdchk(12'h010, 32'h0);
    rdchk(12'h004, 32'h9);
    // run a few ticks, stop, then re-enable on the frozen crystal
    wr(12'h008, 32'h1);
    repeat (3 * TICK) @(posedge ref_clk);
    wr(12'h008, 32'h0);
    wr(12'h018, 32'h1);
    wr(12'h008, 32'h1);
    rdchk(12'h004, 32'h9);
    rdchk(12'h00C, 32'h0);
    finish_test;
  end
endmodule // testbench
